/* hbc_pkg.sv */
/*
  constants for the half-bridge control register bank: frame layout,
  register addresses, field positions, reset values and timing counts.
  assumes a 20 MHz system clock.
*/
package hbc_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int FRAME_W = 16;
  localparam int DATA_W = 11;
  localparam int ADDR_W = 4;
  localparam int ADDR_LSB = 12;
  localparam int WDOG_BIT = 11;
  localparam int BANK_BIT = 10;
  localparam int CHANNELS = 7;
  localparam int CNT_W = 8;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h1;
  localparam logic [3:0] ADDR_PULSE_EN = 4'h2;
  localparam logic [3:0] ADDR_PULSE_SRC = 4'h3;
  localparam logic [3:0] ADDR_CAL = 4'h4;
  localparam logic [3:0] ADDR_CFG_FIRST = 4'h5;
  localparam logic [3:0] ADDR_CFG_LAST = 4'hB;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int GATE_DRIVE_ENABLE_BIT = 10;
  localparam int PUMP_BIT = 9;
  localparam int WD_SEL_BIT = 8;
  localparam int SPLIT_BIT = 7;
  localparam int SRC_LOW_CH = 5;
  localparam int CAL_DLY_LSB = 7;
  localparam int CAL_PC_LSB = 3;
  localparam int CAL_SEL_LSB = 0;
  localparam int BLANK_LSB = 8;
  localparam int IFALL_LSB = 5;
  localparam int IRISE_LSB = 2;
  localparam int TPC_LSB = 0;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [10:0] RST_WORD = 11'h000;
  localparam logic [9:0] RST_CFG = 10'h000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int WD_SHORT_MS = 25;
  localparam int WD_LONG_MS = 500;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * (CLK_HZ / 1000);
  localparam int WD_LONG_CYC = WD_LONG_MS * (CLK_HZ / 1000);
  localparam int CAL_DLY_BASE_NS = 350;
  localparam int CAL_DLY_STEP_NS = 200;
  localparam int CAL_PC_BASE_NS = 50;
  localparam int CAL_PC_STEP_NS = 100;
  localparam int BLANK_BASE_NS = 1000;
  localparam int BLANK_STEP_NS = 1000;
  localparam int TPC_BASE_NS = 100;
  localparam int TPC_STEP_NS = 100;
endpackage : hbc_pkg

/* hbc_spi_rx.sv */
/*
  serial frame port: 16-bit frames, msb first, sampled on falling sclk,
  answer shifted on rising sclk while chip select is low.
  assumes sclk, cs_n and mosi are asynchronous pins; sclk well below
  a quarter of mclk.
*/
`timescale 1ns/1ps
module hbc_spi_rx (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // frame side
  input wire logic [15:0] tx_word_i,
  output logic frame_valid_o,
  output logic [15:0] frame_o
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sclk_q;
  logic cs_q;
  logic [15:0] shift_in;
  logic [15:0] shift_out;
  logic [4:0] bit_cnt;
  logic valid;
  logic [15:0] frame;
  logic [15:0] next_shift_in;
  logic [15:0] next_shift_out;
  logic [4:0] next_bit_cnt;
  logic next_valid;
  logic [15:0] next_frame;
  logic sclk_s;
  logic cs_s;
  logic mosi_s;

  assign sclk_s = sync2[0];
  assign cs_s = sync2[1];
  assign mosi_s = sync2[2];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 3'h2;
      sync2 <= 3'h2;
    end else begin
      sync1 <= {mosi_i, cs_n_i, sclk_i};
      sync2 <= sync1;
    end
  end

  // ----------------------------------------
  // shifting
  // ----------------------------------------
  always_comb begin
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt = bit_cnt;
    next_valid = 1'b0;
    next_frame = frame;
    if (cs_q && !cs_s) begin
      next_bit_cnt = 5'h00;
      next_shift_out = tx_word_i;
    end else if (!cs_s) begin
      if (sclk_q && !sclk_s) begin
        next_shift_in = {shift_in[14:0], mosi_s};
        if (bit_cnt != 5'h1F) begin
          next_bit_cnt = bit_cnt + 5'h01;
        end
      end
      // second rising edge presents bit 14; bit 15 shows from select until then
      if (!sclk_q && sclk_s && bit_cnt != 5'h00) begin
        next_shift_out = {shift_out[14:0], 1'b0};
      end
    end
    // frames of any other length are dropped whole
    if (!cs_q && cs_s && bit_cnt == 5'h10) begin
      next_valid = 1'b1;
      next_frame = shift_in;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
      shift_in <= 16'h0000;
      shift_out <= 16'h0000;
      bit_cnt <= 5'h00;
      valid <= 1'b0;
      frame <= 16'h0000;
    end else begin
      sclk_q <= sclk_s;
      cs_q <= cs_s;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt <= next_bit_cnt;
      valid <= next_valid;
      frame <= next_frame;
    end
  end

  assign miso_o = shift_out[15];
  assign miso_oe_o = !cs_q;
  assign frame_valid_o = valid;
  assign frame_o = frame;
endmodule : hbc_spi_rx

/* hbc_ctrl_regs.sv */
/*
  control register bank of a seven-channel half-bridge pre-driver,
  written by 16-bit serial frames; drives gate on/off commands,
  pump switch, watchdog and calibration/configuration timing counts.
  assumes pulse inputs are asynchronous pins and the channel output
  enables come from same-clock logic.
*/
`timescale 1ns/1ps
module hbc_ctrl_regs #(
  parameter int WD_SHORT = hbc_pkg::WD_SHORT_CYC,
  parameter int WD_LONG = hbc_pkg::WD_LONG_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // pulse inputs and channel enables
  input wire logic [3:0] pulse_input_i,
  input wire logic [6:0] channel_output_enable_i,
  // gate stage
  output logic gate_drive_enable_o,
  output logic switched_pump_pin_o,
  output logic switched_pump_pin_oe_o,
  output logic channel7_split_select_o,
  output logic [6:0] high_gate_on_o,
  output logic [6:0] low_gate_on_o,
  // watchdog
  output logic watchdog_timeout_o,
  // calibration
  output logic [6:0] cal_channel_o,
  output logic [7:0] cal_delay_cycles_o,
  output logic [7:0] cal_precharge_cycles_o,
  // per-channel timing, channel n at bits 8n+7:8n, currents at 3n+2:3n
  output logic [55:0] blanking_cycles_o,
  output logic [55:0] precharge_cycles_o,
  output logic [20:0] fall_precharge_current_o,
  output logic [20:0] rise_precharge_current_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] code_cycles(input int base_ns,
                                             input int step_ns,
                                             input logic [3:0] code);
    int ns;
    ns = base_ns + step_ns * int'(code);
    code_cycles = 8'((ns + hbc_pkg::CLK_PERIOD_NS - 1)
                     / hbc_pkg::CLK_PERIOD_NS);
  endfunction : code_cycles

  // ----------------------------------------
  // reset release and pin sync
  // ----------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  logic [3:0] pulse_s1;
  logic [3:0] pulse_s2;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pulse_s1 <= 4'h0;
      pulse_s2 <= 4'h0;
    end else begin
      pulse_s1 <= pulse_input_i;
      pulse_s2 <= pulse_s1;
    end
  end

  // ----------------------------------------
  // frame port
  // ----------------------------------------
  logic frame_valid;
  logic [15:0] frame;
  logic [15:0] tx_word;
  logic [3:0] f_addr;
  logic [10:0] f_data;
  logic f_wdog;

  hbc_spi_rx u_rx (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .tx_word_i(tx_word),
    .frame_valid_o(frame_valid),
    .frame_o(frame)
  );

  assign f_addr = frame[hbc_pkg::ADDR_LSB +: hbc_pkg::ADDR_W];
  assign f_data = frame[hbc_pkg::DATA_W-1:0];
  assign f_wdog = frame[hbc_pkg::WDOG_BIT];

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  logic [10:0] mode_reg;
  logic [6:0] pulse_en;
  logic [9:0] src_low;
  logic [3:0] src_high;
  logic [10:0] cal_reg;
  logic [9:0] cfg_a [7];
  logic [10:0] readback;
  logic [3:0] last_addr;
  logic [10:0] next_mode_reg;
  logic [6:0] next_pulse_en;
  logic [9:0] next_src_low;
  logic [3:0] next_src_high;
  logic [10:0] next_cal_reg;
  logic [9:0] next_cfg_a [7];
  logic [10:0] next_readback;
  logic [3:0] next_last_addr;

  always_comb begin
    next_mode_reg = mode_reg;
    next_pulse_en = pulse_en;
    next_src_low = src_low;
    next_src_high = src_high;
    next_cal_reg = cal_reg;
    next_cfg_a = cfg_a;
    next_readback = readback;
    next_last_addr = last_addr;
    if (frame_valid) begin
      next_last_addr = f_addr;
      next_readback = f_data;
      if (f_addr == hbc_pkg::ADDR_MODE) begin
        next_mode_reg = f_data;
      end else if (f_addr == hbc_pkg::ADDR_PULSE_EN) begin
        next_pulse_en = f_data[6:0]; // bits 10:7 ignored
      end else if (f_addr == hbc_pkg::ADDR_PULSE_SRC) begin
        if (!f_data[hbc_pkg::BANK_BIT]) begin
          next_src_low = f_data[9:0];
        end else begin
          next_src_high = f_data[3:0];
        end
      end else if (f_addr == hbc_pkg::ADDR_CAL) begin
        next_cal_reg = f_data;
      end else if (f_addr >= hbc_pkg::ADDR_CFG_FIRST &&
                   f_addr <= hbc_pkg::ADDR_CFG_LAST &&
                   !f_data[hbc_pkg::BANK_BIT]) begin
        // second config word lives elsewhere; only bank 0 stored here
        next_cfg_a[3'(f_addr - hbc_pkg::ADDR_CFG_FIRST)] = f_data[9:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= hbc_pkg::RST_WORD;
      pulse_en <= 7'h00;
      src_low <= 10'h000;
      src_high <= 4'h0;
      cal_reg <= hbc_pkg::RST_WORD;
      for (int i = 0; i < hbc_pkg::CHANNELS; i++) begin
        cfg_a[i] <= hbc_pkg::RST_CFG;
      end
      readback <= hbc_pkg::RST_WORD;
      last_addr <= 4'h0;
    end else begin
      mode_reg <= next_mode_reg;
      pulse_en <= next_pulse_en;
      src_low <= next_src_low;
      src_high <= next_src_high;
      cal_reg <= next_cal_reg;
      cfg_a <= next_cfg_a;
      readback <= next_readback;
      last_addr <= next_last_addr;
    end
  end

  // ----------------------------------------
  // watchdog: a frame whose watchdog bit toggles restarts the count
  // ----------------------------------------
  logic [23:0] wd_cnt;
  logic wd_last;
  logic wd_expired;
  logic [23:0] next_wd_cnt;
  logic next_wd_last;
  logic next_wd_expired;
  logic [23:0] wd_limit;

  assign wd_limit = mode_reg[hbc_pkg::WD_SEL_BIT] ? 24'(WD_LONG - 1)
                                                  : 24'(WD_SHORT - 1);

  always_comb begin
    next_wd_cnt = wd_cnt;
    next_wd_last = wd_last;
    next_wd_expired = wd_expired;
    if (frame_valid && f_wdog != wd_last) begin
      next_wd_cnt = 24'h000000;
      next_wd_last = f_wdog;
      next_wd_expired = 1'b0;
    end else if (wd_cnt >= wd_limit) begin
      next_wd_expired = 1'b1;
    end else begin
      next_wd_cnt = wd_cnt + 24'h000001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt <= 24'h000000;
      wd_last <= 1'b0;
      wd_expired <= 1'b0;
    end else begin
      wd_cnt <= next_wd_cnt;
      wd_last <= next_wd_last;
      wd_expired <= next_wd_expired;
    end
  end

  // ----------------------------------------
  // gate commands
  // ----------------------------------------
  logic [13:0] src_all;
  logic [6:0] next_high;
  logic [6:0] next_low;
  logic [6:0] high_q;
  logic [6:0] low_q;
  logic gate_drive_enable;

  assign src_all = {src_high, src_low};
  assign gate_drive_enable = mode_reg[hbc_pkg::GATE_DRIVE_ENABLE_BIT];

  always_comb begin
    logic drive;
    drive = 1'b0;
    next_high = 7'h00;
    next_low = 7'h00;
    for (int c = 0; c < hbc_pkg::CHANNELS; c++) begin
      drive = !pulse_en[c] || pulse_s2[src_all[2*c +: 2]];
      // host keeps enables low while retuning, so no glitch guard here
      drive = drive && gate_drive_enable && channel_output_enable_i[c];
      if (c == hbc_pkg::CHANNELS - 1 && mode_reg[hbc_pkg::SPLIT_BIT]) begin
        next_high[c] = drive;
        next_low[c] = drive;
      end else begin
        next_high[c] = drive && mode_reg[c];
        next_low[c] = drive && !mode_reg[c];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      high_q <= 7'h00;
      low_q <= 7'h00;
    end else begin
      high_q <= next_high;
      low_q <= next_low;
    end
  end

  // ----------------------------------------
  // calibration and channel timing
  // ----------------------------------------
  always_comb begin
    logic [2:0] sel;
    sel = cal_reg[hbc_pkg::CAL_SEL_LSB +: 3];
    cal_channel_o = 7'h00;
    if (sel != 3'h0) begin
      cal_channel_o[3'(sel - 3'h1)] = 1'b1;
    end
  end

  assign cal_delay_cycles_o = code_cycles(hbc_pkg::CAL_DLY_BASE_NS,
    hbc_pkg::CAL_DLY_STEP_NS, cal_reg[hbc_pkg::CAL_DLY_LSB +: 4]);
  assign cal_precharge_cycles_o = code_cycles(hbc_pkg::CAL_PC_BASE_NS,
    hbc_pkg::CAL_PC_STEP_NS, cal_reg[hbc_pkg::CAL_PC_LSB +: 4]);

  always_comb begin
    for (int c = 0; c < hbc_pkg::CHANNELS; c++) begin
      blanking_cycles_o[8*c +: 8] = code_cycles(hbc_pkg::BLANK_BASE_NS,
        hbc_pkg::BLANK_STEP_NS, {2'h0, cfg_a[c][hbc_pkg::BLANK_LSB +: 2]});
      // duration steps are host-paced one code at a time
      precharge_cycles_o[8*c +: 8] = code_cycles(hbc_pkg::TPC_BASE_NS,
        hbc_pkg::TPC_STEP_NS, {2'h0, cfg_a[c][hbc_pkg::TPC_LSB +: 2]});
      fall_precharge_current_o[3*c +: 3] = cfg_a[c][hbc_pkg::IFALL_LSB +: 3];
      rise_precharge_current_o[3*c +: 3] = cfg_a[c][hbc_pkg::IRISE_LSB +: 3];
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tx_word = {last_addr, wd_expired, readback};
  assign gate_drive_enable_o = gate_drive_enable;
  assign switched_pump_pin_o = 1'b1;
  assign switched_pump_pin_oe_o = mode_reg[hbc_pkg::PUMP_BIT] && gate_drive_enable;
  assign channel7_split_select_o = mode_reg[hbc_pkg::SPLIT_BIT];
  assign high_gate_on_o = high_q;
  assign low_gate_on_o = low_q;
  assign watchdog_timeout_o = wd_expired;
endmodule : hbc_ctrl_regs

/* hbc_ctrl_props.sv */
/*
  assertions on the outputs of the half-bridge control register bank.
  assumes it is bound into hbc_ctrl_regs; one clock domain.
*/
`timescale 1ns/1ps
module hbc_ctrl_props (
  // clock, reset and inputs
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic [6:0] channel_output_enable_i,
  // watched outputs
  input wire logic gate_drive_enable_o,
  input wire logic switched_pump_pin_o,
  input wire logic switched_pump_pin_oe_o,
  input wire logic channel7_split_select_o,
  input wire logic [6:0] high_gate_on_o,
  input wire logic [6:0] low_gate_on_o,
  input wire logic [6:0] cal_channel_o,
  input wire logic [7:0] cal_delay_cycles_o,
  input wire logic [7:0] cal_precharge_cycles_o,
  input wire logic [55:0] blanking_cycles_o
);
  // only four blanking counts exist, one per code
  logic blank_ok;
  always_comb begin
    blank_ok = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (!(blanking_cycles_o[8*i+:8] inside {8'h14, 8'h28, 8'h3C, 8'h50}))
        blank_ok = 1'b0;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  chk_pump_needs_drive: assert property (
    switched_pump_pin_oe_o |-> gate_drive_enable_o && switched_pump_pin_o)
    else $error("pump pin driven without drive enable");
  chk_gates_need_drive: assert property (
    !$past(gate_drive_enable_o) |-> (high_gate_on_o | low_gate_on_o) == 7'h00)
    else $error("gate on while drive disabled");
  chk_gate_needs_enable: assert property (
    ((high_gate_on_o | low_gate_on_o) & ~$past(channel_output_enable_i))
    == 7'h00) else $error("gate on while channel disabled");
  chk_side_exclusive: assert property (
    (high_gate_on_o & low_gate_on_o & 7'h3F) == 7'h00)
    else $error("both sides on in one channel");
  chk_split_both_on: assert property (
    high_gate_on_o[6] && low_gate_on_o[6] |-> $past(channel7_split_select_o))
    else $error("channel seven both sides on without split");
  chk_cal_one_target: assert property (
    $onehot0(cal_channel_o)) else $error("calibration target not one-hot");
  chk_cal_delay_step: assert property (
    cal_delay_cycles_o inside {[8'h07:8'h43]}
    && cal_delay_cycles_o[1:0] == 2'h3)
    else $error("calibration delay count off grid");
  chk_cal_pc_step: assert property (
    cal_precharge_cycles_o[0] && cal_precharge_cycles_o <= 8'h1F)
    else $error("calibration pre-charge count off grid");
  chk_blank_grid: assert property (
    blank_ok) else $error("blanking count off grid");
  chk_mode_holds: assert property (
    cs_n_i [*8] |-> $stable(gate_drive_enable_o) && $stable(cal_channel_o)
    && $stable(channel7_split_select_o)) else $error("register moved idle");
  cov_split: cover property (high_gate_on_o[6] && low_gate_on_o[6]);
  cov_pump: cover property ($rose(switched_pump_pin_oe_o));
  cov_cal_top: cover property (cal_channel_o[6]);
endmodule : hbc_ctrl_props

bind hbc_ctrl_regs hbc_ctrl_props u_props (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
  .channel_output_enable_i(channel_output_enable_i),
  .gate_drive_enable_o(gate_drive_enable_o),
  .switched_pump_pin_o(switched_pump_pin_o),
  .switched_pump_pin_oe_o(switched_pump_pin_oe_o),
  .channel7_split_select_o(channel7_split_select_o),
  .high_gate_on_o(high_gate_on_o), .low_gate_on_o(low_gate_on_o),
  .cal_channel_o(cal_channel_o), .cal_delay_cycles_o(cal_delay_cycles_o),
  .cal_precharge_cycles_o(cal_precharge_cycles_o),
  .blanking_cycles_o(blanking_cycles_o)
);

/* hbc_host_model.sv */
/*
  serial host model: sends 16-bit frames msb first, sclk idle low.
  assumes the device samples on falling sclk; half period of 4 mclk.
*/
`timescale 1ns/1ps
module hbc_host_model (
  // clock
  input wire logic mclk_i,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // answer word of the last frame, sampled just before each falling sclk
  logic [15:0] rx_word;
  initial begin
    rx_word = 16'h0000;
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk_i);
    #5;
  endtask : wait_clk
  task automatic send_frame(input logic [15:0] word);
    cs_n_o = 1'b0;
    wait_clk(4);
    for (int i = 15; i >= 0; i--) begin
      mosi_o = word[i];
      sclk_o = 1'b1;
      wait_clk(4);
      rx_word = {rx_word[14:0], miso_i};
      sclk_o = 1'b0;
      wait_clk(4);
    end
    cs_n_o = 1'b1;
    // deselected line must not keep showing the last bit
    mosi_o = ~mosi_o;
    wait_clk(8);
  endtask : send_frame
endmodule : hbc_host_model

/* hbc_ctrl_regs_test.sv */
/*
  self-checking bench for hbc_ctrl_regs: frames from the host model,
  gate, calibration, configuration and watchdog outputs compared.
  assumes short watchdog counts handed in through the parameters.
*/
`timescale 1ns/1ps
module hbc_ctrl_regs_test;
  localparam int WD_S = 50;
  localparam int WD_L = 200;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, cs_n, mosi, drv, pump, pump_oe, split, wdt;
  logic miso, miso_oe;
  logic [3:0] pulse = 4'h0;
  logic [6:0] chen = 7'h00;
  logic [6:0] hi, lo, cal_ch;
  logic [7:0] cal_dly, cal_pc;
  logic [55:0] blank, tpc;
  logic [20:0] ifall, irise;
  logic wd_bit = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 mclk = ~mclk;
  hbc_ctrl_regs #(.WD_SHORT(WD_S), .WD_LONG(WD_L)) uut (
    .mclk_i(mclk), .nrst_i(nrst), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .pulse_input_i(pulse),
    .channel_output_enable_i(chen), .gate_drive_enable_o(drv),
    .switched_pump_pin_o(pump), .switched_pump_pin_oe_o(pump_oe),
    .channel7_split_select_o(split), .high_gate_on_o(hi),
    .low_gate_on_o(lo), .watchdog_timeout_o(wdt), .cal_channel_o(cal_ch),
    .cal_delay_cycles_o(cal_dly), .cal_precharge_cycles_o(cal_pc),
    .blanking_cycles_o(blank), .precharge_cycles_o(tpc),
    .fall_precharge_current_o(ifall), .rise_precharge_current_o(irise));
  hbc_host_model host (.mclk_i(mclk), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso));
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // hang guard: the whole run needs well under 10000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      complete_run();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask : tick
  task automatic chk(input string what, input logic [55:0] exp,
                     input logic [55:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    host.send_frame({a, wd_bit, d});
  endtask : wr
  // channels are parked while their settings change
  task automatic wrq(input logic [3:0] a, input logic [10:0] d);
    chen = 7'h00;
    tick(1);
    wr(a, d);
    chen = 7'h7F;
    tick(3);
  endtask : wrq
  task automatic t_reset();
    chen = 7'h7F;
    pulse = 4'hF;
    tick(6);
    chk("gates", 14'h0000, {hi, lo});
    chk("pump oe", 1'b0, pump_oe);
    chk("split", 1'b0, split);
    chk("cal ch", 7'h00, cal_ch);
    chk("cal dly", 8'h07, cal_dly);
    chk("cal pc", 8'h01, cal_pc);
    chk("blank", {7{8'h14}}, blank);
    chk("tpc", {7{8'h02}}, tpc);
    chk("miso oe", 1'b0, miso_oe);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mode();
    wrq(hbc_pkg::ADDR_MODE, 11'h455);
    chk("high", 7'h55, hi);
    chk("low", 7'h2A, lo);
    chk("pump oe", 1'b0, pump_oe);
    wrq(hbc_pkg::ADDR_MODE, 11'h6C0);
    chk("pump oe", 1'b1, pump_oe);
    chk("split", 1'b1, split);
    chk("high", 7'h40, hi);
    chk("low", 7'h7F, lo);
    wrq(hbc_pkg::ADDR_MODE, 11'h27F);
    chk("off", 15'h0000, {pump_oe, hi, lo});
    $display("test mode done");
  endtask : t_mode
  task automatic t_pulse();
    logic [1:0] src [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1, 2'h3};
    logic [6:0] en = 7'h5F;
    logic [6:0] exp;
    wrq(hbc_pkg::ADDR_MODE, 11'h400);
    wrq(hbc_pkg::ADDR_PULSE_SRC, 11'h0E4);
    wrq(hbc_pkg::ADDR_PULSE_SRC, 11'h40D);
    wrq(hbc_pkg::ADDR_PULSE_EN, 11'h7DF);
    for (int k = 0; k < 4; k++) begin
      pulse = 4'h1 << k;
      tick(5);
      for (int i = 0; i < 7; i++)
        exp[i] = en[i] ? (src[i] == k) : 1'b1;
      chk("pulse low", exp, lo);
    end
    $display("test pulse done");
  endtask : t_pulse
  task automatic t_cal();
    for (int c = 0; c < 8; c++) begin
      wr(hbc_pkg::ADDR_CAL, {4'(2 * c + 1), 4'(14 - 2 * c), 3'(c)});
      chk("cal ch", c == 0 ? 7'h00 : 7'h01 << (c - 1), cal_ch);
      chk("cal dly", 8'(11 + 8 * c), cal_dly);
      chk("cal pc", 8'(29 - 4 * c), cal_pc);
      // answer echoes the previous frame; watchdog long expired by now
      if (c > 0)
        chk("readback", {hbc_pkg::ADDR_CAL, 1'b1, 4'(2 * c - 1),
            4'(16 - 2 * c), 3'(c - 1)}, host.rx_word);
    end
    $display("test calibration done");
  endtask : t_cal
  task automatic t_cfg();
    logic [3:0] adr;
    logic [55:0] exp;
    adr = 4'(hbc_pkg::ADDR_CFG_FIRST + 2);
    for (int t = 1; t < 4; t++) begin
      wrq(adr, {9'h0EB, 2'(t)});
      exp = {7{8'h02}};
      exp[23:16] = 8'(2 * (t + 1));
      chk("tpc", exp, tpc);
    end
    wrq(adr, 11'h400);
    exp = {7{8'h14}};
    exp[23:16] = 8'h50;
    chk("blank", exp, blank);
    chk("fall", 3'h5, ifall[8:6]);
    chk("rise", 3'h3, irise[8:6]);
    $display("test config done");
  endtask : t_cfg
  task automatic t_wdog();
    wd_bit = ~wd_bit;
    wrq(hbc_pkg::ADDR_MODE, 11'h400);
    tick(WD_S - 15);
    chk("wdog short early", 1'b0, wdt);
    tick(20);
    chk("wdog short late", 1'b1, wdt);
    wd_bit = ~wd_bit;
    wrq(hbc_pkg::ADDR_MODE, 11'h500);
    tick(WD_L - 20);
    chk("wdog long early", 1'b0, wdt);
    tick(30);
    chk("wdog long late", 1'b1, wdt);
    $display("test watchdog done");
  endtask : t_wdog
  initial begin
    tick(20);
    nrst = 1'b1;
    tick(8);
    t_reset();
    t_mode();
    t_pulse();
    t_cal();
    t_cfg();
    t_wdog();
    complete_run();
  end
endmodule : hbc_ctrl_regs_test
